// file: core/psc_pkg.sv
// Constants and types for the protection switch control block
package psc_pkg;
  // Register byte offsets
  localparam logic [7:0] PSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSC_MAN_OFS  = 8'h04;
  localparam logic [7:0] PSC_STAT_OFS = 8'h08;
  // Control register fields
  localparam int PSC_C_TX_AUTO = 0;
  localparam int PSC_C_RX_AUTO = 1;
  localparam int PSC_C_TX_PRIO = 2;
  localparam int PSC_C_RX_PRIO = 3;
  localparam int PSC_C_RX_FORC = 4;
  localparam int PSC_C_EW_INCL = 5;
  localparam int PSC_C_XR_INCL = 6;
  localparam int PSC_C_HS_EN   = 7;
  localparam int PSC_C_THR_LSB = 8;
  localparam int PSC_CTRL_W    = 10;
  // Auto on both sides, threshold index 1 (one in ten million)
  localparam logic [9:0] PSC_CTRL_RST = 10'h103;
  // Manual command register fields
  localparam int PSC_M_TX_CH2 = 0;
  localparam int PSC_M_RX_CH2 = 1;
  localparam int PSC_M_OPX_LSB = 2;
  // Status register fields
  localparam int PSC_S_TX_LSB  = 0;
  localparam int PSC_S_RX_LSB  = 2;
  localparam int PSC_S_RXA_LSB = 4;
  localparam int PSC_S_TXA_LSB = 6;
  localparam int PSC_S_XR_LSB  = 8;
  localparam int PSC_S_REFUSED = 10;
  localparam int PSC_S_MRX_LSB = 11;
  localparam int PSC_S_MTX_LSB = 13;
  // FIFO defaults
  localparam int PSC_FIFO_W = 32;
  localparam int PSC_FIFO_D = 4;
  // Channel selection, one-hot
  typedef enum logic [1:0] {
    PSC_CH1 = 2'b01,
    PSC_CH2 = 2'b10
  } psc_sel_t;
endpackage : psc_pkg

// file: core/psc_top.sv
// Protection switch control: selector, mute control, FIFO and APB registers
//
// Contract
// - Both demodulated streams reach the selector; only the chosen one goes on.
// - Channel 1 low error-rate alarm makes the receive selector pick channel 2.
// - In hot-standby, transmit alarms switch transmission to the healthy unit.
// - Active outdoor unit un-mutes, the other mutes; exactly one transmits.
// - Transmit and receive states drive two indicators each.
// - Transmit switching is automatic from failures or manual from craft terminal.
// - Receive switching is automatic on signal degradation or manual.
// - Priority: non-revertive, or channel 1 whenever both are healthy.
// - Priority applies only under automatic control.
// - Manual and automatic are independent; returning to auto re-selects.
// - Non-forced maintenance refuses manual receive commands during any alarm.
// - Forced maintenance obeys manual receive commands despite alarms.
// - Early warning included switches at the most sensitive level.
// - Early warning excluded uses selectable threshold, default one in ten million.
// - Cross-reset included makes canceller reset trigger receive switchover.
// - Cross-reset excluded leaves selection unaffected by canceller reset.
// - Canceller reset from sync loss, IF loss, loopback, operator or peer.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Plain synchronous FIFO, registered full and empty
module psc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
    $error("psc_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      cnt_next;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data  = mem_reg[rd_reg];

  // Storage write
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers, fill count and flags taken from the next count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      cnt_reg   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg   <= cnt_next;
      in_ready  <= (cnt_next != DEPTH_C);   // Registered, so ready leaves a flip-flop
      out_valid <= (cnt_next != '0);
    end
  end
endmodule : psc_fifo

module psc_top
  import psc_pkg::*;
#(
  parameter int DATA_W = PSC_FIFO_W,
  parameter int FIFO_D = PSC_FIFO_D
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Modem alarms, index 0 is channel 1
  input  wire logic [1:0]        mod_alarm,
  input  wire logic [1:0]        ew_alarm,
  input  wire logic [3:0]        ch1_low_error_rate_alarm,
  input  wire logic [3:0]        ch2_low_error_rate_alarm,
  // Outdoor unit alarms
  input  wire logic [1:0]        txif_alarm,
  input  wire logic [1:0]        txpwr_alarm,
  input  wire logic [1:0]        power_loop_alarm,
  // Canceller reset causes
  input  wire logic [1:0]        frame_sync_loss,
  input  wire logic [1:0]        xpol_if_loss,
  input  wire logic [1:0]        if_loopback,
  input  wire logic [1:0]        xpol_reset_req,
  // Demodulated streams
  input  wire logic [DATA_W-1:0] ch1_data,
  input  wire logic              ch1_valid,
  input  wire logic [DATA_W-1:0] ch2_data,
  input  wire logic              ch2_valid,
  output logic                   demod_ready,
  // Stream to multiplexer
  output logic [DATA_W-1:0]      mux_data,
  output logic                   mux_valid,
  input  wire logic              mux_ready,
  // Controls and indicators
  output logic [1:0]             outdoor_unit_mute,
  output logic [1:0]             transmit_path_indicators,
  output logic [1:0]             receive_path_indicators,
  output logic [1:0]             cross_polar_canceller_reset
);
  if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
    $error("psc_top: DATA_W must be 1..32");
  end

  logic [PSC_CTRL_W-1:0] ctrl_reg;
  logic [1:0]  opx_reg;
  logic        refused_reg;
  psc_sel_t    rx_sel_reg, tx_sel_reg, rx_man_reg, tx_man_reg;
  logic [1:0]  rx_alm, tx_alm, xrst;
  logic [1:0]  rx_thr;
  logic        wr_acc, rd_acc, man_wr, rx_cmd_ok;
  logic        fifo_in_valid;
  logic [DATA_W-1:0] fifo_in_data;
  logic [31:0] rd_mux;
  logic        hit;

  // Pick next channel under auto control
  function automatic psc_sel_t psc_auto(psc_sel_t cur, logic [1:0] alm, logic prio);
    psc_auto = cur;
    if (prio && !alm[0]) psc_auto = PSC_CH1;
    else if (cur == PSC_CH1 && alm[0] && !alm[1]) psc_auto = PSC_CH2;
    else if (cur == PSC_CH2 && alm[1] && !alm[0]) psc_auto = PSC_CH1;
  endfunction : psc_auto

  // Per-channel alarm gathering
  assign rx_thr = ctrl_reg[PSC_C_THR_LSB +: 2];
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [3:0] ber;
    assign ber = (i == 0) ? ch1_low_error_rate_alarm : ch2_low_error_rate_alarm;
    // Canceller reset sources
    assign xrst[i] = frame_sync_loss[i] | xpol_if_loss[i] | if_loopback[i]
                   | opx_reg[i] | xpol_reset_req[i];
    // Receive route alarm
    assign rx_alm[i] = (ctrl_reg[PSC_C_EW_INCL] ? ew_alarm[i]
                                                : ber[rx_thr])
                     | (ctrl_reg[PSC_C_XR_INCL] & xrst[i]);
    // Transmit section alarm
    assign tx_alm[i] = mod_alarm[i] | txif_alarm[i] | txpwr_alarm[i]
                     | power_loop_alarm[i];
  end

  // APB decode
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign hit    = (paddr == PSC_CTRL_OFS) | (paddr == PSC_MAN_OFS)
                | (paddr == PSC_STAT_OFS);
  assign man_wr = wr_acc & (paddr == PSC_MAN_OFS) & ~pslverr;
  assign rx_cmd_ok = ctrl_reg[PSC_C_RX_FORC] | (rx_alm == 2'b00);

  // Read data selection
  always_comb begin
    rd_mux = '0;
    case (paddr)
      PSC_CTRL_OFS: rd_mux[PSC_CTRL_W-1:0] = ctrl_reg;
      PSC_MAN_OFS: begin
        rd_mux[PSC_M_TX_CH2]       = (tx_man_reg == PSC_CH2);
        rd_mux[PSC_M_RX_CH2]       = (rx_man_reg == PSC_CH2);
        rd_mux[PSC_M_OPX_LSB +: 2] = opx_reg;
      end
      PSC_STAT_OFS: begin
        rd_mux[PSC_S_TX_LSB +: 2]  = tx_sel_reg;
        rd_mux[PSC_S_RX_LSB +: 2]  = rx_sel_reg;
        rd_mux[PSC_S_RXA_LSB +: 2] = rx_alm;
        rd_mux[PSC_S_TXA_LSB +: 2] = tx_alm;
        rd_mux[PSC_S_XR_LSB +: 2]  = xrst;
        rd_mux[PSC_S_REFUSED]      = refused_reg;
        rd_mux[PSC_S_MRX_LSB +: 2] = rx_man_reg;
        rd_mux[PSC_S_MTX_LSB +: 2] = tx_man_reg;
      end
      default: rd_mux = '0;
    endcase
  end

  // APB handshake: one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_acc) prdata <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= PSC_CTRL_RST;
    end else if (wr_acc && paddr == PSC_CTRL_OFS) begin
      ctrl_reg <= pwdata[PSC_CTRL_W-1:0];
    end
  end

  // Manual commands, kept apart from auto state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_man_reg  <= PSC_CH1;
      rx_man_reg  <= PSC_CH1;
      opx_reg     <= 2'b00;
      refused_reg <= 1'b0;
    end else if (man_wr) begin
      tx_man_reg <= pwdata[PSC_M_TX_CH2] ? PSC_CH2 : PSC_CH1;
      opx_reg    <= pwdata[PSC_M_OPX_LSB +: 2];
      refused_reg <= ~rx_cmd_ok;
      if (rx_cmd_ok)
        rx_man_reg <= pwdata[PSC_M_RX_CH2] ? PSC_CH2 : PSC_CH1;
    end
  end

  // Receive selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sel_reg <= PSC_CH1;
    end else if (ctrl_reg[PSC_C_RX_AUTO]) begin
      rx_sel_reg <= psc_auto(rx_sel_reg, rx_alm, ctrl_reg[PSC_C_RX_PRIO]);
    end else begin
      rx_sel_reg <= rx_man_reg;
    end
  end

  // Transmit selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_reg <= PSC_CH1;
    end else if (ctrl_reg[PSC_C_TX_AUTO]) begin
      tx_sel_reg <= psc_auto(tx_sel_reg, tx_alm, ctrl_reg[PSC_C_TX_PRIO]);
    end else begin
      tx_sel_reg <= tx_man_reg;
    end
  end

  // Mutes, indicators and canceller reset outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outdoor_unit_mute           <= 2'b00;
      transmit_path_indicators    <= 2'b00;
      receive_path_indicators     <= 2'b00;
      cross_polar_canceller_reset <= 2'b00;
    end else begin
      outdoor_unit_mute <= ctrl_reg[PSC_C_HS_EN] ? ~tx_sel_reg : 2'b00;
      transmit_path_indicators <= tx_sel_reg;
      receive_path_indicators  <= rx_sel_reg;
      cross_polar_canceller_reset <= xrst;
    end
  end

  // Hitless selector into the FIFO
  assign fifo_in_valid = (rx_sel_reg == PSC_CH1) ? ch1_valid : ch2_valid;
  assign fifo_in_data  = (rx_sel_reg == PSC_CH1) ? ch1_data : ch2_data;

  psc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (demod_ready),
    .out_valid (mux_valid),
    .out_data  (mux_data),
    .out_ready (mux_ready)
  );

  // Checks
  a_rx_fail_over: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_RX_AUTO] && rx_sel_reg == PSC_CH1 && rx_alm == 2'b01
    |=> rx_sel_reg == PSC_CH2 ##1 receive_path_indicators == PSC_CH2)
    else $error("receive did not move to channel 2");
  a_rx_both_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_RX_AUTO] && rx_alm == 2'b11 |=> $stable(rx_sel_reg))
    else $error("selection moved with both channels in alarm");
  a_rx_prio_ch1: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_RX_AUTO] && ctrl_reg[PSC_C_RX_PRIO] && !rx_alm[0]
    |=> rx_sel_reg == PSC_CH1)
    else $error("priority did not return to channel 1");
  a_rx_no_revert: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_RX_AUTO] && !ctrl_reg[PSC_C_RX_PRIO]
    && (rx_alm & rx_sel_reg) == 2'b00 |=> $stable(rx_sel_reg))
    else $error("non-priority selection reverted");
  a_tx_one_live: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_HS_EN] && $past(ctrl_reg[PSC_C_HS_EN])
    |-> $onehot(outdoor_unit_mute) && outdoor_unit_mute == ~transmit_path_indicators)
    else $error("not exactly one outdoor unit live");
  a_tx_auto_sw: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_TX_AUTO] && ctrl_reg[PSC_C_HS_EN] && tx_sel_reg == PSC_CH2
    && tx_alm == 2'b10 |=> tx_sel_reg == PSC_CH1 ##1 outdoor_unit_mute == 2'b10)
    else $error("transmit did not move to healthy unit");
  a_rx_man_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    man_wr && !ctrl_reg[PSC_C_RX_FORC] && rx_alm != 2'b00
    |=> $stable(rx_man_reg) && refused_reg)
    else $error("manual receive command taken during alarm");
  a_rx_man_force: assert property (@(posedge pclk) disable iff (!presetn)
    man_wr && ctrl_reg[PSC_C_RX_FORC]
    |=> rx_man_reg == ($past(pwdata[PSC_M_RX_CH2]) ? PSC_CH2 : PSC_CH1))
    else $error("forced manual receive command not obeyed");
  a_rx_man_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[PSC_C_RX_AUTO] |=> rx_sel_reg == $past(rx_man_reg))
    else $error("manual receive selection not followed");
  a_xr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[PSC_C_XR_INCL] && !ctrl_reg[PSC_C_EW_INCL]
    |-> rx_alm == {ch2_low_error_rate_alarm[rx_thr], ch1_low_error_rate_alarm[rx_thr]})
    else $error("canceller reset reached receive alarm");

  // Indicator, stream, canceller, early warning, mute and manual transmit checks
  a_tx_ind_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> transmit_path_indicators == $past(tx_sel_reg))
    else $error("transmit indicators do not follow selection");
  a_rx_ind_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> receive_path_indicators == $past(rx_sel_reg))
    else $error("receive indicators do not follow selection");
  a_mux_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mux_valid && !mux_ready
    |=> mux_valid && $stable(mux_data))
    else $error("stream word dropped or changed while stalled");
  a_fifo_keep_full: assert property (@(posedge pclk) disable iff (!presetn)
    !demod_ready && !mux_ready
    |=> !demod_ready)
    else $error("full buffer took a word without a pop");
  a_xr_switch: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_XR_INCL]
    |-> (rx_alm & xrst) == xrst)
    else $error("canceller reset did not raise receive alarm");
  a_xr_out: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> cross_polar_canceller_reset == $past(frame_sync_loss | xpol_if_loss | if_loopback
                                            | xpol_reset_req | opx_reg))
    else $error("canceller reset output wrong");
  a_ew_level: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[PSC_C_EW_INCL] && !ctrl_reg[PSC_C_XR_INCL]
    |-> rx_alm == ew_alarm)
    else $error("early warning did not set receive alarm");
  a_tx_no_mute: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[PSC_C_HS_EN]
    |=> outdoor_unit_mute == 2'b00)
    else $error("outdoor unit muted outside hot-standby");
  a_tx_man_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[PSC_C_TX_AUTO]
    |=> tx_sel_reg == $past(tx_man_reg))
    else $error("manual transmit selection not followed");
endmodule : psc_top

`default_nettype wire

// file: verification/psc_far.sv
// Far-side model: two modem streams and two outdoor units
`timescale 1ns/1ps
`default_nettype none

module psc_far #(
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Modem streams
  input  wire logic          run,
  input  wire logic          demod_ready,
  output logic [DW-1:0]      ch1_data,
  output logic [DW-1:0]      ch2_data,
  output logic               ch_valid,
  // Outdoor units
  input  wire logic [1:0]    outdoor_unit_mute,
  output logic [1:0]         odu_on
);
  logic [15:0] cnt;
  logic        stall;

  // Word counter shared by both modems, idling now and then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= 16'h0;
      stall <= 1'h0;
    end else begin
      stall <= cnt[1:0] == 2'h3 && !stall;
      if (ch_valid && demod_ready) cnt <= cnt + 16'h1;
    end
  end

  // Idle lines show the inverse word, never a stale copy
  assign ch_valid = run && !stall;
  assign ch1_data = ch_valid ? DW'({16'h1, cnt}) : ~DW'({16'h1, cnt});
  assign ch2_data = ch_valid ? DW'({16'h2, cnt}) : ~DW'({16'h2, cnt});
  // A unit transmits unless muted
  assign odu_on = ~outdoor_unit_mute;
endmodule : psc_far

`default_nettype wire

// file: verification/psc_top_test.sv
// Self-checking bench for the protection switch control block
`timescale 1ns/1ps
`default_nettype none

module psc_top_test
  import psc_pkg::*;
;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        mux_ready, run, ch_valid, demod_ready, mux_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, mux_data, ch1_data, ch2_data;
  logic [3:0]  l1, l2;
  logic [1:0]  mda, ew, tif, tpw, plp, fsl, xil, ilb, xrr;
  logic [1:0]  mute, tpi, rpi, xcr, odu_on, exp_rx, exp_tx;
  integer      seed;
  int          fail_count, check_count;
  logic [31:0] q[$];

  // Clock, 5 ns period
  always #2.5 pclk = ~pclk;

  psc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_alarm(mda), .ew_alarm(ew), .ch1_low_error_rate_alarm(l1),
    .ch2_low_error_rate_alarm(l2), .txif_alarm(tif), .txpwr_alarm(tpw),
    .power_loop_alarm(plp), .frame_sync_loss(fsl), .xpol_if_loss(xil),
    .if_loopback(ilb), .xpol_reset_req(xrr), .ch1_data(ch1_data), .ch1_valid(ch_valid),
    .ch2_data(ch2_data), .ch2_valid(ch_valid), .demod_ready(demod_ready),
    .mux_data(mux_data), .mux_valid(mux_valid), .mux_ready(mux_ready),
    .outdoor_unit_mute(mute), .transmit_path_indicators(tpi),
    .receive_path_indicators(rpi), .cross_polar_canceller_reset(xcr));

  psc_far #(.DW(32)) far (.pclk(pclk), .presetn(presetn), .run(run),
    .demod_ready(demod_ready), .ch1_data(ch1_data), .ch2_data(ch2_data),
    .ch_valid(ch_valid), .outdoor_unit_mute(mute), .odu_on(odu_on));

  // Compare and count
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Reference selection: priority, else leave an alarmed channel for a healthy one
  function automatic logic [1:0] nxt(logic [1:0] c, logic a1, a2, p);
    if (p && !a1) return 2'h1;
    if (c == 2'h1 && a1 && !a2) return 2'h2;
    if (c == 2'h2 && a2 && !a1) return 2'h1;
    return c;
  endfunction : nxt

  task automatic rx_ev(input logic a1, a2, p, input string m);
    exp_rx = nxt(exp_rx, a1, a2, p);
    repeat (3) @(posedge pclk);
    chk(32'(rpi), 32'(exp_rx), m);
  endtask : rx_ev

  task automatic tx_ev(input logic a1, a2, input string m);
    exp_tx = nxt(exp_tx, a1, a2, 1'h0);
    repeat (3) @(posedge pclk);
    chk(32'({tpi, mute, odu_on}), 32'({exp_tx, ~exp_tx, exp_tx}), m);
  endtask : tx_ev

  // Drive one canceller reset cause, the operator one through the register
  task automatic cause(input int c, input logic [1:0] v);
    case (c)
      0: fsl <= v;
      1: xil <= v;
      2: ilb <= v;
      3: xrr <= v;
      default: apb(1'h1, PSC_MAN_OFS, 32'({v, 2'h0}));
    endcase
  endtask : cause

  // Drive one kind of transmit alarm
  task automatic txa(input int k, input logic [1:0] v);
    case (k)
      0: mda <= v;
      1: tif <= v;
      2: tpw <= v;
      default: plp <= v;
    endcase
  endtask : txa

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  // Words of the selected stream must leave in order
  always @(negedge pclk) begin
    if (ch_valid && demod_ready) q.push_back(exp_rx == 2'h1 ? ch1_data : ch2_data);
    if (mux_valid && mux_ready) chk(mux_data, q.size() ? q.pop_front() : ~mux_data, "word");
  end

  // Watchdog
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    seed = 6;
    {presetn, psel, penable, pwrite, mux_ready, run} = '0;
    {l1, l2, mda, ew, tif, tpw, plp, fsl, xil, ilb, xrr} = '0;
    paddr = '0;
    pwdata = '0;
    exp_rx = 2'h1;
    exp_tx = 2'h1;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk(32'({rpi, tpi, mute, xcr}), 32'h50, "reset outputs");
    apb(1'h0, PSC_CTRL_OFS, '0);
    chk(rd, 32'(PSC_CTRL_RST), "ctrl reset");
    apb(1'h0, PSC_STAT_OFS, '0);
    chk(rd, 32'h5 | (32'h1 << PSC_S_MRX_LSB) | (32'h1 << PSC_S_MTX_LSB), "stat reset");
    apb(1'h1, 8'h0c, '1);
    apb(1'h0, 8'h0c, '0);
    chk(rd | 32'(er), 32'h1, "unmapped");
    // Fill until refused, drain at random, then stall the source
    run <= 1'h1;
    repeat (12) @(posedge pclk);
    chk(32'({demod_ready, mux_valid}), 32'h1, "fifo full");
    repeat (60) begin
      @(posedge pclk);
      mux_ready <= 1'($random(seed));
    end
    run <= 1'h0;
    mux_ready <= 1'h1;
    for (int i = 0; i < 20 && mux_valid !== 1'h0; i++) @(posedge pclk);
    chk(32'({mux_valid, q.size() == 0}), 32'h1, "fifo empty");
    // Every threshold, with the next finer bit ignored
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, PSC_CTRL_OFS, 32'h3 + (32'(k) << 8));
      if (k < 3) begin
        l1 <= 4'(2 << k);
        rx_ev(1'h0, 1'h0, 1'h0, "below threshold");
      end
      l1 <= 4'(1 << k);
      rx_ev(1'h1, 1'h0, 1'h0, "ch1 alarm");
      l1 <= 4'h0;
      rx_ev(1'h0, 1'h0, 1'h0, "non revertive");
      l2 <= 4'(1 << k);
      rx_ev(1'h0, 1'h1, 1'h0, "ch2 alarm");
      l2 <= 4'h0;
    end
    apb(1'h1, PSC_CTRL_OFS, 32'h123);
    l1 <= 4'hf;
    rx_ev(1'h0, 1'h0, 1'h0, "ew ignores threshold");
    ew <= 2'h1;
    rx_ev(1'h1, 1'h0, 1'h0, "ew ch1");
    l1 <= 4'h0;
    ew <= 2'h2;
    rx_ev(1'h0, 1'h1, 1'h0, "ew ch2");
    ew <= 2'h0;
    apb(1'h1, PSC_CTRL_OFS, 32'h10b);
    l1 <= 4'h2;
    rx_ev(1'h1, 1'h0, 1'h1, "prio ch1 alarm");
    l1 <= 4'h0;
    rx_ev(1'h0, 1'h0, 1'h1, "prio return");
    {l1, l2} <= 8'h22;
    rx_ev(1'h1, 1'h1, 1'h1, "both alarmed");
    l2 <= 4'h0;
    rx_ev(1'h1, 1'h0, 1'h1, "leave alarmed");
    l1 <= 4'h0;
    // Canceller reset causes with cross reset included, then excluded
    apb(1'h1, PSC_CTRL_OFS, 32'h14b);
    for (int c = 0; c < 5; c++) begin
      cause(c, 2'h1);
      rx_ev(1'h1, 1'h0, 1'h1, "cross reset");
      chk(32'(xcr), 32'h1, "canceller reset");
      cause(c, 2'h0);
      rx_ev(1'h0, 1'h0, 1'h1, "cross reset over");
    end
    apb(1'h1, PSC_CTRL_OFS, 32'h10b);
    fsl <= 2'h1;
    rx_ev(1'h0, 1'h0, 1'h1, "no cross reset");
    chk(32'(xcr), 32'h1, "canceller reset");
    fsl <= 2'h0;
    // Manual receive control
    apb(1'h1, PSC_CTRL_OFS, 32'h109);
    apb(1'h1, PSC_MAN_OFS, 32'h2);
    exp_rx = 2'h2;
    rx_ev(1'h0, 1'h0, 1'h0, "manual ignores prio");
    l2 <= 4'h2;
    apb(1'h1, PSC_MAN_OFS, 32'h0);
    rx_ev(1'h0, 1'h0, 1'h0, "manual refused");
    apb(1'h0, PSC_STAT_OFS, '0);
    chk(32'(rd[PSC_S_REFUSED]), 32'h1, "refused flag");
    apb(1'h1, PSC_CTRL_OFS, 32'h119);
    apb(1'h1, PSC_MAN_OFS, 32'h0);
    exp_rx = 2'h1;
    rx_ev(1'h0, 1'h0, 1'h0, "forced manual");
    l2 <= 4'h0;
    l1 <= 4'h2;
    rx_ev(1'h0, 1'h0, 1'h0, "manual holds");
    apb(1'h1, PSC_CTRL_OFS, 32'h103);
    rx_ev(1'h1, 1'h0, 1'h0, "auto reselect");
    l1 <= 4'h0;
    // Hot standby transmit switching, every alarm kind
    apb(1'h1, PSC_CTRL_OFS, 32'h183);
    tx_ev(1'h0, 1'h0, "standby mute");
    for (int k = 0; k < 4; k++) begin
      txa(k, exp_tx);
      tx_ev(exp_tx[0], exp_tx[1], "tx alarm");
      txa(k, 2'h0);
      tx_ev(1'h0, 1'h0, "tx hold");
    end
    apb(1'h1, PSC_CTRL_OFS, 32'h182);
    apb(1'h1, PSC_MAN_OFS, 32'h1);
    exp_tx = 2'h2;
    tx_ev(1'h0, 1'h0, "tx manual ch2");
    apb(1'h1, PSC_MAN_OFS, 32'h0);
    exp_tx = 2'h1;
    tx_ev(1'h0, 1'h0, "tx manual ch1");
    complete_run();
  end
endmodule : psc_top_test

`default_nettype wire
